// File: core/temp_alarm_filter.sv
`timescale 1ns/100ps
module temp_alarm_filter
  import temp_monitor_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic refresh,
  input wire logic signed [TEMP_W-1:0] temperature,
  input wire cmp_cfg_t cfg,
  output logic alarm
);

  logic raw;
  logic [CNT_W-1:0] count;
  logic next_raw;
  logic [CNT_W-1:0] next_count;
  logic next_alarm;
  logic signed [THR_W-1:0] thr;
  logic signed [CMP_W-1:0] thr_q;
  logic signed [CMP_W-1:0] hyst_q;
  logic signed [CMP_W-1:0] temp_q;
  logic [CNT_W-1:0] depth;

  always_comb begin
    thr = cfg.thr;
    if (thr < THR_MIN) begin
      thr = THR_MIN;
    end
    if (thr > THR_MAX) begin
      thr = THR_MAX;
    end
    thr_q = CMP_W'(thr) <<< QUARTER_SHIFT;
    hyst_q = signed'(CMP_W'(cfg.hyst)) <<< QUARTER_SHIFT;
    temp_q = CMP_W'(temperature);
    depth = CNT_W'(cfg.depth_m1) + CNT_W'(1);
    next_raw = raw;
    next_count = (count > depth) ? depth : count;
    next_alarm = alarm;
    if (refresh) begin
      // the hysteresis band lies below the trip point when guarding heat, above it otherwise
      if (!cfg.under_temperature_setting) begin
        next_raw = raw ? (temp_q > thr_q - hyst_q) : (temp_q > thr_q);
      end else begin
        next_raw = raw ? (temp_q > thr_q) : (temp_q > thr_q + hyst_q);
      end
      if (next_raw) begin
        if (next_count < depth) begin
          next_count = next_count + CNT_W'(1);
        end
      end else if (next_count != '0) begin
        next_count = next_count - CNT_W'(1);
      end
      if (next_count == depth) begin
        next_alarm = 1'b1;
      end else if (next_count == '0) begin
        next_alarm = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw <= 1'b0;
      count <= '0;
      alarm <= 1'b0;
    end else begin
      raw <= next_raw;
      count <= next_count;
      alarm <= next_alarm;
    end
  end

endmodule : temp_alarm_filter

// File: core/temp_monitor.sv
`timescale 1ns/100ps
module temp_monitor
  import temp_monitor_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic conv_start,
  output logic [CH_W-1:0] conv_channel,
  input wire logic conv_done,
  input wire adc_result_t conv_result,
  output logic [CHANNELS-1:0] temp_alarm_a,
  output logic [CHANNELS-1:0] temp_alarm_b
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    reg_sel_t d;
    logic [CH_W-1:0] blk;
    logic [2:0] word;
    d.kind = SEL_NONE;
    d.ch = '0;
    blk = CH_W'(a >> CH_SHIFT);
    word = 3'(a >> WORD_SHIFT);
    if (a == CTRL_OFS) begin
      d.kind = SEL_CTRL;
    end else if (a == STATUS_OFS) begin
      d.kind = SEL_STATUS;
    end else if (blk != '0 && a[WORD_SHIFT-1:0] == '0) begin
      d.ch = blk - CH_W'(1);
      unique case (word)
        W_CFG: d.kind = SEL_CFG;
        W_CMP_A: d.kind = SEL_CMP_A;
        W_CMP_B: d.kind = SEL_CMP_B;
        W_AVG_HI: d.kind = SEL_AVG_HI;
        W_AVG_LO: d.kind = SEL_AVG_LO;
        W_MEAS: d.kind = SEL_MEAS;
        default: d.kind = SEL_NONE;
      endcase
    end
    return d;
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r & mask;
  endfunction : merge

  function automatic cmp_cfg_t unpack_cmp(input logic [31:0] w);
    cmp_cfg_t c;
    c.under_temperature_setting = w[MODE_BIT];
    c.depth_m1 = w[DEPTH_LSB +: DEPTH_W];
    c.hyst = w[HYST_LSB +: HYST_W];
    c.thr = w[THR_LSB +: THR_W];
    return c;
  endfunction : unpack_cmp

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic aw_got;
  logic [ADDR_W-1:0] aw_addr;
  logic w_got;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] ctrl;
  logic [31:0] cfg_word [CHANNELS];
  logic [31:0] cmpa_word [CHANNELS];
  logic [31:0] cmpb_word [CHANNELS];
  logic next_aw_got;
  logic [ADDR_W-1:0] next_aw_addr;
  logic next_w_got;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] next_ctrl;
  logic [31:0] next_cfg_word [CHANNELS];
  logic [31:0] next_cmpa_word [CHANNELS];
  logic [31:0] next_cmpb_word [CHANNELS];

  sched_state_t state;
  sched_state_t next_state;
  logic [31:0] slot_cnt;
  logic [31:0] next_slot_cnt;
  logic next_conv_start;
  logic [CH_W-1:0] next_conv_channel;

  logic signed [TEMP_W-1:0] meas [CHANNELS];
  logic signed [ACC_W-1:0] acc [CHANNELS];
  logic [CHANNELS-1:0] avg_valid;
  logic [CHANNELS-1:0] refresh;
  logic signed [TEMP_W-1:0] next_meas [CHANNELS];
  logic signed [ACC_W-1:0] next_acc [CHANNELS];
  logic [CHANNELS-1:0] next_avg_valid;
  logic [CHANNELS-1:0] next_refresh;

  reg_sel_t wsel;
  reg_sel_t rsel;
  logic [CHANNELS-1:0] ch_en;

  assign ch_en = ctrl[EN_LSB +: CHANNELS];
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // ---------------------------------------------------------------
  // register slave
  // ---------------------------------------------------------------
  always_comb begin
    next_aw_got = aw_got;
    next_aw_addr = aw_addr;
    next_w_got = w_got;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_ctrl = ctrl;
    next_cfg_word = cfg_word;
    next_cmpa_word = cmpa_word;
    next_cmpb_word = cmpb_word;
    wsel = decode(aw_addr);
    rsel = decode(s_axi_araddr);
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (aw_got && w_got) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case (wsel.kind)
        SEL_CTRL: next_ctrl = merge(ctrl, w_data, w_strb, CTRL_MASK);
        SEL_CFG: next_cfg_word[wsel.ch] = merge(cfg_word[wsel.ch], w_data, w_strb, CFG_MASK);
        SEL_CMP_A: next_cmpa_word[wsel.ch] = merge(cmpa_word[wsel.ch], w_data, w_strb, CMP_MASK);
        SEL_CMP_B: next_cmpb_word[wsel.ch] = merge(cmpb_word[wsel.ch], w_data, w_strb, CMP_MASK);
        SEL_STATUS, SEL_AVG_HI, SEL_AVG_LO, SEL_MEAS: next_bresp = RESP_OKAY;
        SEL_NONE: next_bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      unique case (rsel.kind)
        SEL_CTRL: next_rdata = ctrl;
        SEL_STATUS: begin
          next_rdata[ST_ALARM_LSB +: 2*CHANNELS] = {temp_alarm_b, temp_alarm_a};
          next_rdata[ST_VALID_LSB +: CHANNELS] = avg_valid;
          next_rdata[ST_CH_LSB +: CH_W] = conv_channel;
        end
        SEL_CFG: next_rdata = cfg_word[rsel.ch];
        SEL_CMP_A: next_rdata = cmpa_word[rsel.ch];
        SEL_CMP_B: next_rdata = cmpb_word[rsel.ch];
        // averaged value split in a pair: upper eight bits, then low three
        SEL_AVG_HI: next_rdata[TEMP_W-AVG_LO_W-1:0] =
          (TEMP_W-AVG_LO_W)'((acc[rsel.ch] >>> AVG_FRAC) >> AVG_LO_W);
        SEL_AVG_LO: next_rdata[AVG_LO_W-1:0] = AVG_LO_W'(acc[rsel.ch] >>> AVG_FRAC);
        SEL_MEAS: next_rdata[TEMP_W-1:0] = meas[rsel.ch];
        SEL_NONE: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_addr <= '0;
      w_got <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      ctrl <= CTRL_RESET;
      for (int i = 0; i < CHANNELS; i++) begin
        cfg_word[i] <= CFG_RESET;
        cmpa_word[i] <= CMP_RESET;
        cmpb_word[i] <= CMP_RESET;
      end
    end else begin
      aw_got <= next_aw_got;
      aw_addr <= next_aw_addr;
      w_got <= next_w_got;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      ctrl <= next_ctrl;
      cfg_word <= next_cfg_word;
      cmpa_word <= next_cmpa_word;
      cmpb_word <= next_cmpb_word;
    end
  end

  // ---------------------------------------------------------------
  // round-robin conversion scheduler
  // ---------------------------------------------------------------
  always_comb begin
    logic [CH_W-1:0] pick;
    logic found;
    pick = conv_channel;
    found = 1'b0;
    next_state = state;
    next_slot_cnt = (slot_cnt == '0) ? 32'(SLOT_LEN - 1) : slot_cnt - 32'h1;
    next_conv_start = 1'b0;
    next_conv_channel = conv_channel;
    for (int i = 1; i <= CHANNELS; i++) begin
      if (!found && ch_en[(int'(conv_channel) + i) % CHANNELS]) begin
        found = 1'b1;
        pick = CH_W'((int'(conv_channel) + i) % CHANNELS);
      end
    end
    unique case (state)
      SCHED_WAIT: begin
        // one slot per enabled channel, so refresh and settling stretch with channel count
        if (slot_cnt == '0 && found) begin
          next_conv_start = 1'b1;
          next_conv_channel = pick;
          next_state = SCHED_CONVERT;
        end
      end
      SCHED_CONVERT: begin
        if (conv_done) begin
          next_state = SCHED_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SCHED_WAIT;
      slot_cnt <= '0;
      conv_start <= 1'b0;
      conv_channel <= CH_W'(CHANNELS - 1);
    end else begin
      state <= next_state;
      slot_cnt <= next_slot_cnt;
      conv_start <= next_conv_start;
      conv_channel <= next_conv_channel;
    end
  end

  // ---------------------------------------------------------------
  // conversion and averaging
  // ---------------------------------------------------------------
  always_comb begin
    logic [GAIN_W-1:0] gain;
    logic [PROD_W-1:0] prod;
    logic signed [CALC_W-1:0] celsius;
    logic signed [TEMP_W-1:0] sample;
    logic signed [ACC_W-1:0] diff;
    logic [COEF_W-1:0] coef;
    int sh;
    gain = cfg_word[conv_channel][GAIN_LSB +: GAIN_W];
    if (gain < GAIN_MIN) begin
      gain = GAIN_MIN;
    end
    if (gain > GAIN_MAX) begin
      gain = GAIN_MAX;
    end
    prod = PROD_W'(conv_result.kelvin) * PROD_W'(gain);
    celsius = signed'(CALC_W'(prod >> GAIN_FRAC)) - ZERO_C_QUARTERS
      + CALC_W'(signed'(cfg_word[conv_channel][OFFSET_LSB +: OFFSET_W]));
    if (celsius > TEMP_MAX) begin
      celsius = TEMP_MAX;
    end
    if (celsius < TEMP_MIN) begin
      celsius = TEMP_MIN;
    end
    sample = TEMP_W'(celsius);
    // with the swap bit the short and open codes trade places
    if (conv_result.shorted) begin
      sample = ctrl[FAULT_SWAP_BIT] ? FAULT_HIGH : FAULT_LOW;
    end else if (conv_result.open) begin
      sample = ctrl[FAULT_SWAP_BIT] ? FAULT_LOW : FAULT_HIGH;
    end
    coef = cfg_word[conv_channel][COEF_LSB +: COEF_W];
    sh = (coef == '0) ? 0 : (coef == COEF_W'(1)) ? SHIFT_COEF_8 : SHIFT_COEF_16;
    diff = (ACC_W'(sample) <<< AVG_FRAC) - acc[conv_channel];
    next_meas = meas;
    next_acc = acc;
    next_avg_valid = avg_valid;
    next_refresh = '0;
    if (state == SCHED_CONVERT && conv_done) begin
      next_meas[conv_channel] = sample;
      next_refresh[conv_channel] = 1'b1;
      next_avg_valid[conv_channel] = 1'b1;
      if (!avg_valid[conv_channel]) begin
        next_acc[conv_channel] = ACC_W'(sample) <<< AVG_FRAC;
      end else begin
        // fractional bits kept so coefficient 16 still creeps toward small steps
        next_acc[conv_channel] = acc[conv_channel] + (diff >>> sh);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      avg_valid <= '0;
      refresh <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        meas[i] <= '0;
        acc[i] <= '0;
      end
    end else begin
      meas <= next_meas;
      acc <= next_acc;
      avg_valid <= next_avg_valid;
      refresh <= next_refresh;
    end
  end

  // ---------------------------------------------------------------
  // trip comparators and alarm filters
  // ---------------------------------------------------------------
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    temp_alarm_filter u_cmp_a (
      .aclk(aclk),
      .aresetn(aresetn),
      .refresh(refresh[c]),
      .temperature(meas[c]),
      .cfg(unpack_cmp(cmpa_word[c])),
      .alarm(temp_alarm_a[c])
    );
    temp_alarm_filter u_cmp_b (
      .aclk(aclk),
      .aresetn(aresetn),
      .refresh(refresh[c]),
      .temperature(meas[c]),
      .cfg(unpack_cmp(cmpb_word[c])),
      .alarm(temp_alarm_b[c])
    );
  end

endmodule : temp_monitor

// File: core/temp_monitor_pkg.sv
package temp_monitor_pkg;

  // ---------------------------------------------------------------
  // sizes and arithmetic
  // ---------------------------------------------------------------
  localparam int CHANNELS = 3;
  localparam int TEMP_W = 11;
  localparam int KELVIN_W = 12;
  localparam int GAIN_W = 13;
  localparam int GAIN_FRAC = 12;
  localparam int CALC_W = 16;
  localparam int PROD_W = GAIN_FRAC + CALC_W;
  localparam int OFFSET_W = 9;
  localparam int COEF_W = 2;
  localparam int AVG_FRAC = 4;
  localparam int ACC_W = 16;
  localparam int THR_W = 9;
  localparam int HYST_W = 6;
  localparam int DEPTH_W = 4;
  localparam int CNT_W = 5;
  localparam int CMP_W = 13;
  localparam int QUARTER_SHIFT = 2;
  localparam int CH_W = 2;

  // gain is 4096 / ideality: 2.0 -> 2048, 0.9 -> 4551, 1.0 -> 4096
  localparam logic [GAIN_W-1:0] GAIN_MIN = 13'h0800;
  localparam logic [GAIN_W-1:0] GAIN_MAX = 13'h11c7;
  localparam logic signed [CALC_W-1:0] ZERO_C_QUARTERS = 16'sh0445;
  localparam logic signed [CALC_W-1:0] TEMP_MAX = 16'sh03ff;
  localparam logic signed [CALC_W-1:0] TEMP_MIN = -16'sh03ff;
  localparam logic [TEMP_W-1:0] FAULT_HIGH = 11'h3ff;
  localparam logic [TEMP_W-1:0] FAULT_LOW = 11'h401;
  localparam logic signed [THR_W-1:0] THR_MIN = -9'sh040;
  localparam logic signed [THR_W-1:0] THR_MAX = 9'sh09b;
  localparam int SHIFT_COEF_8 = 3;
  localparam int SHIFT_COEF_16 = 4;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int SLOT_TIME_US = 14200;
  localparam int SLOT_CYCLES = SLOT_TIME_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam int CH_SHIFT = 5;
  localparam int WORD_SHIFT = 2;
  localparam logic [2:0] W_CFG = 3'h0;
  localparam logic [2:0] W_CMP_A = 3'h1;
  localparam logic [2:0] W_CMP_B = 3'h2;
  localparam logic [2:0] W_AVG_HI = 3'h3;
  localparam logic [2:0] W_AVG_LO = 3'h4;
  localparam logic [2:0] W_MEAS = 3'h5;

  localparam int EN_LSB = 0;
  localparam int FAULT_SWAP_BIT = 8;
  localparam int GAIN_LSB = 0;
  localparam int OFFSET_LSB = 16;
  localparam int COEF_LSB = 28;
  localparam int THR_LSB = 0;
  localparam int HYST_LSB = 12;
  localparam int DEPTH_LSB = 20;
  localparam int MODE_BIT = 31;
  localparam int ST_ALARM_LSB = 0;
  localparam int ST_VALID_LSB = 8;
  localparam int ST_CH_LSB = 12;
  localparam int AVG_LO_W = 3;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0007;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0107;
  localparam logic [31:0] CFG_RESET = 32'h0000_1000;
  localparam logic [31:0] CFG_MASK = 32'h31ff_1fff;
  localparam logic [31:0] CMP_RESET = 32'h0000_009b;
  localparam logic [31:0] CMP_MASK = 32'h80f3_f1ff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [KELVIN_W-1:0] kelvin;
    logic shorted;
    logic open;
  } adc_result_t;

  typedef struct packed {
    logic under_temperature_setting;
    logic [DEPTH_W-1:0] depth_m1;
    logic [HYST_W-1:0] hyst;
    logic signed [THR_W-1:0] thr;
  } cmp_cfg_t;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_CTRL, SEL_STATUS, SEL_CFG, SEL_CMP_A, SEL_CMP_B,
    SEL_AVG_HI, SEL_AVG_LO, SEL_MEAS
  } sel_kind_t;

  typedef struct packed {
    sel_kind_t kind;
    logic [CH_W-1:0] ch;
  } reg_sel_t;

  typedef enum logic {SCHED_WAIT, SCHED_CONVERT} sched_state_t;

endpackage : temp_monitor_pkg

// File: test/adc_model.sv
`timescale 1ns/100ps
module adc_model
  import temp_monitor_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_start,
  input wire logic [CH_W-1:0] conv_channel,
  input wire logic [3:0] delay,
  input wire adc_result_t sample [CHANNELS],
  output logic conv_done,
  output adc_result_t conv_result
);
  logic busy;
  logic [3:0] cnt;
  always_ff @(posedge aclk) begin
    conv_done <= 1'b0;
    // result lines toggle outside the done cycle so a stale value never matches
    conv_result <= ~conv_result;
    if (!aresetn) begin
      busy <= 1'b0;
      conv_result <= '0;
    end else if (conv_start) begin
      busy <= 1'b1;
      cnt <= delay;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      conv_done <= 1'b1;
      conv_result <= sample[conv_channel];
    end
  end
endmodule : adc_model

// File: test/temp_monitor_sva.sv
`timescale 1ns/100ps
module temp_monitor_sva
  import temp_monitor_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_start,
  input wire logic [CH_W-1:0] conv_channel,
  input wire logic conv_done,
  input wire logic [CHANNELS-1:0] temp_alarm_a,
  input wire logic [CHANNELS-1:0] temp_alarm_b
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer not held");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer not held");
  property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_one_wr; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_one_wr: assert property (p_one_wr) else $error("write taken while answering");
  // ---------------------------------------------------------------
  // conversion schedule and alarms
  // ---------------------------------------------------------------
  property p_slot; conv_start |-> conv_channel < CHANNELS ##1 !conv_start [*8]; endproperty
  a_slot: assert property (p_slot) else $error("start spacing or channel wrong");
  // alarms only move two edges after a refresh
  property p_alarm_a; temp_alarm_a != $past(temp_alarm_a) |-> $past(conv_done, 2); endproperty
  a_alarm_a: assert property (p_alarm_a) else $error("alarm a moved off refresh");
  property p_alarm_b; temp_alarm_b != $past(temp_alarm_b) |-> $past(conv_done, 2); endproperty
  a_alarm_b: assert property (p_alarm_b) else $error("alarm b moved off refresh");
endmodule : temp_monitor_sva

bind temp_monitor temp_monitor_sva temp_monitor_sva_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .conv_start,
  .conv_channel, .conv_done, .temp_alarm_a, .temp_alarm_b);

// File: test/testbench.sv
`timescale 1ns/100ps
module testbench
  import temp_monitor_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, delay;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic conv_start, conv_done;
  logic [CH_W-1:0] conv_channel;
  logic [CHANNELS-1:0] temp_alarm_a, temp_alarm_b;
  adc_result_t conv_result;
  adc_result_t sample [CHANNELS];
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  temp_monitor #(.SLOT_LEN(20)) temp_monitor_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_start, .conv_channel, .conv_done,
    .conv_result, .temp_alarm_a, .temp_alarm_b);
  adc_model adc_model_i (.aclk, .aresetn, .conv_start, .conv_channel, .delay, .sample,
    .conv_done, .conv_result);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  function automatic logic [7:0] ra(input int c, input logic [2:0] w);
    return 8'((c + 1) << CH_SHIFT) | (8'(w) << WORD_SHIFT);
  endfunction : ra

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ka = 1'b0, kw = 1'b0, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ka = ka | s_axi_awready;
      kw = kw | s_axi_wready;
      @(posedge aclk);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
    end while (!(ka && kw));
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ok;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ok = s_axi_arready;
      @(posedge aclk);
    end while (!ok);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ok = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
    end while (!ok);
    s_axi_rready <= 1'b0;
  endtask : rd

  // returns three edges after the refresh, when the alarm outputs have settled
  task automatic upd(input int c);
    do @(negedge aclk); while (!(conv_done === 1'b1 && conv_channel == c));
    repeat (3) @(negedge aclk);
  endtask : upd

  task automatic chk_avg(input logic [10:0] exp);
    logic [31:0] hi;
    rd(ra(0, W_AVG_HI), hi, r);
    rd(ra(0, W_AVG_LO), d, r);
    check({hi[7:0], d[2:0]}, 32'(exp));
  endtask : chk_avg

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(CTRL_OFS, d, r);
    check(d, CTRL_RESET);
    rd(ra(0, W_CFG), d, r);
    check(d, CFG_RESET);
    rd(ra(2, W_CMP_B), d, r);
    check(d, CMP_RESET);
    rd(8'hfc, d, r);
    check(d, 32'h0);
    check(r, RESP_SLVERR);
    wr(8'hfc, 32'h1, r);
    check(r, RESP_SLVERR);
    wr(STATUS_OFS, 32'hffff_ffff, r);
    check(r, RESP_OKAY);
  endtask : t_reset

  task automatic t_convert();
    logic [10:0] exp [CHANNELS] = '{11'd100, -11'sd349, 11'd755};
    sample = '{'{12'd1193, 1'b0, 1'b0}, '{12'd2000, 1'b0, 1'b0}, '{12'd1593, 1'b0, 1'b0}};
    wr(ra(1, W_CFG), 32'h0100_0800, r);
    wr(ra(2, W_CFG), 32'h00ff_1000, r);
    for (int c = 0; c < CHANNELS; c++) begin
      upd(c);
      upd(c);
      rd(ra(c, W_MEAS), d, r);
      check(d[10:0], exp[c]);
    end
    wr(CTRL_OFS, 32'h5, r);
    upd(0);
    for (int i = 0; i < 3; i++) begin
      do @(negedge aclk); while (conv_start !== 1'b1);
      check(conv_channel, i[0] ? 2'd0 : 2'd2);
    end
  endtask : t_convert

  task automatic t_fault();
    delay = 4'hc;
    for (int i = 0; i < 4; i++) begin
      wr(CTRL_OFS, {23'h0, i[1], 8'h7}, r);
      sample[2] = '{12'd1193, !i[0], i[0]};
      upd(2);
      upd(2);
      rd(ra(2, W_MEAS), d, r);
      check(d[10:0], (!i[0] ^ i[1]) ? FAULT_LOW : FAULT_HIGH);
    end
    delay = 4'h3;
  endtask : t_fault

  task automatic t_avg();
    wr(CTRL_OFS, 32'h1, r);
    upd(0);
    upd(0);
    chk_avg(11'd100);
    sample[0] = '{12'd1273, 1'b0, 1'b0};
    wr(ra(0, W_CFG), 32'h1000_1000, r);
    upd(0);
    chk_avg(11'd110);
    upd(0);
    chk_avg(11'd118);
    wr(ra(0, W_CFG), 32'h2000_1000, r);
    upd(0);
    chk_avg(11'd122);
  endtask : t_avg

  task automatic t_alarm();
    int deg [10] = '{20, 40, 40, 40, 28, 32, 20, 20, 20, 40};
    logic [9:0] ea = 10'h0f8;
    logic [9:0] eb = 10'h20e;
    sample[0] = '{12'd1173, 1'b0, 1'b0};
    wr(ra(0, W_CMP_A), 32'h0020_501e, r);
    wr(ra(0, W_CMP_B), 32'h8000_501e, r);
    upd(0);
    // the comparators read the raw value, so averaging at coefficient 16 does not slow these steps
    for (int i = 0; i < 10; i++) begin
      sample[0].kelvin = 12'(1093 + 4 * deg[i]);
      upd(0);
      check({temp_alarm_b, temp_alarm_a}, {eb[i], 2'b0, ea[i]});
    end
  endtask : t_alarm

  // ---------------------------------------------------------------
  // clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    delay = 4'h3;
    sample = '{default: '0};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_convert();
    t_fault();
    t_avg();
    t_alarm();
    complete_run();
  end
endmodule : testbench
